// ==== rtl/pin_mux_pkg.sv ====
// Package for the port pin override multiplexer.
// Assumes one I/O clock and a port of fixed width.
package pin_mux_pkg;
    // =========================================================
    // Port geometry
    localparam int unsigned PORT_WIDTH = 8;
    localparam int unsigned ALT_PINS   = 5;
    // =========================================================
    // Reset values of the port registers
    localparam logic [PORT_WIDTH-1:0] DIR_RESET  = 8'h00;
    localparam logic [PORT_WIDTH-1:0] OUT_RESET  = 8'h00;
    localparam logic [PORT_WIDTH-1:0] PULL_RESET = 8'h00;
    localparam logic [PORT_WIDTH-1:0] SYNC_RESET = 8'h00;
    // =========================================================
    // Alternative function pin positions on the port
    localparam int unsigned PIN_A0 = 0;
    localparam int unsigned PIN_A1 = 1;
    localparam int unsigned PIN_A2 = 2;
    localparam int unsigned PIN_A3 = 3;
    localparam int unsigned PIN_A4 = 4;
endpackage : pin_mux_pkg

// ==== rtl/pin_override_cell.sv ====
// One pin's override logic: pull-up, driver, value, input enable.
// Assumes register bits and overrides come from the I/O clock domain.
module pin_override_cell (
    // Port register bits
    input  wire logic pullup_reg_bit_in,
    input  wire logic direction_reg_bit_in,
    input  wire logic output_reg_bit_in,
    // Overrides from peripherals
    input  wire logic pullup_override_en_in,
    input  wire logic pullup_override_val_in,
    input  wire logic dir_override_en_in,
    input  wire logic dir_override_val_in,
    input  wire logic value_override_en_in,
    input  wire logic value_override_val_in,
    input  wire logic input_en_override_en_in,
    input  wire logic input_en_override_val_in,
    // Sleep clamp and external interrupt enable
    input  wire logic sleep_in,
    input  wire logic ext_int_en_in,
    // Pad controls
    output logic      pullup_en_out,
    output logic      drive_en_out,
    output logic      drive_val_out,
    output logic      input_en_out
);
    always_comb begin
        pullup_en_out = pullup_override_en_in ? pullup_override_val_in : pullup_reg_bit_in;
        drive_en_out  = dir_override_en_in ? dir_override_val_in : direction_reg_bit_in;
        drive_val_out = value_override_en_in ? value_override_val_in : output_reg_bit_in;
        if (input_en_override_en_in) begin
            input_en_out = input_en_override_val_in;
        end else begin
            input_en_out = ~sleep_in | ext_int_en_in;
        end
    end
endmodule // pin_override_cell

// ==== rtl/port_pin_override_mux.sv ====
// Port pin override multiplexer: register bits, overrides, pad paths.
// Assumes peripherals present override pairs on mclk_in; pads are async.
module port_pin_override_mux
    import pin_mux_pkg::*;
(
    // Clock, reset and sleep
    input  wire logic                                     mclk_in,
    input  wire logic                                     rst_n_in,
    input  wire logic                                     sleep_in,
    // Shared port strobes and write data
    input  wire logic                                     dir_write_strobe_in,
    input  wire logic                                     port_write_strobe_in,
    input  wire logic                                     pull_write_strobe_in,
    input  wire logic                                     toggle_write_strobe_in,
    input  wire logic [pin_mux_pkg::PORT_WIDTH-1:0]       write_data_in,
    // Register read back
    output logic      [pin_mux_pkg::PORT_WIDTH-1:0]       direction_reg_bit_out,
    output logic      [pin_mux_pkg::PORT_WIDTH-1:0]       output_reg_bit_out,
    output logic      [pin_mux_pkg::PORT_WIDTH-1:0]       pullup_reg_bit_out,
    output logic      [pin_mux_pkg::PORT_WIDTH-1:0]       pin_read_bit_out,
    // Per-pin overrides from peripherals
    input  wire logic [pin_mux_pkg::PORT_WIDTH-1:0]       pullup_override_en_in,
    input  wire logic [pin_mux_pkg::PORT_WIDTH-1:0]       pullup_override_val_in,
    input  wire logic [pin_mux_pkg::PORT_WIDTH-1:0]       dir_override_en_in,
    input  wire logic [pin_mux_pkg::PORT_WIDTH-1:0]       dir_override_val_in,
    input  wire logic [pin_mux_pkg::PORT_WIDTH-1:0]       value_override_en_in,
    input  wire logic [pin_mux_pkg::PORT_WIDTH-1:0]       value_override_val_in,
    input  wire logic [pin_mux_pkg::PORT_WIDTH-1:0]       toggle_override_en_in,
    input  wire logic [pin_mux_pkg::PORT_WIDTH-1:0]       input_en_override_en_in,
    input  wire logic [pin_mux_pkg::PORT_WIDTH-1:0]       input_en_override_val_in,
    input  wire logic [pin_mux_pkg::PORT_WIDTH-1:0]       ext_int_en_in,
    // Pad side
    input  wire logic [pin_mux_pkg::PORT_WIDTH-1:0]       pad_in,
    output logic      [pin_mux_pkg::PORT_WIDTH-1:0]       pad_out,
    output logic      [pin_mux_pkg::PORT_WIDTH-1:0]       pad_oe_out,
    output logic      [pin_mux_pkg::PORT_WIDTH-1:0]       pad_pullup_out,
    // Analog link, both directions as two signals
    input  wire logic [pin_mux_pkg::PORT_WIDTH-1:0]       analog_pad_link_in,
    output logic      [pin_mux_pkg::PORT_WIDTH-1:0]       analog_pad_link_out,
    // Raw input to peripherals
    output logic      [pin_mux_pkg::PORT_WIDTH-1:0]       raw_digital_in_out,
    // Named alternative taps, bits 0 to 4
    output logic                                          pin_change_src_0_out,
    output logic                                          miso_alt_in_out,
    output logic                                          converter_chan_0_out,
    output logic                                          ext_voltage_ref_out,
    output logic                                          comp0_pos_in_out,
    output logic                                          mosi_alt_in_out,
    output logic                                          comp0_neg_in_out,
    output logic                                          serial0_rx_out,
    output logic                                          select_alt_in_out,
    output logic                                          comp1_pos_in_out,
    output logic                                          timer0_clk_in_out,
    output logic                                          serial0_xfer_clk_out,
    output logic                                          sck_alt_in_out,
    output logic                                          comp1_neg_in_out,
    output logic                                          timer1_clk_in_out,
    output logic                                          serial1_rx_out,
    output logic                                          wire_clk_in_out,
    output logic                                          sck_dflt_in_out
);
    import pin_mux_pkg::*;

    // =========================================================
    // Internal state and pad control vectors
    logic [PORT_WIDTH-1:0] dir_q;
    logic [PORT_WIDTH-1:0] out_q;
    logic [PORT_WIDTH-1:0] pull_q;
    logic [PORT_WIDTH-1:0] sync1_q;
    logic [PORT_WIDTH-1:0] sync2_q;
    logic [PORT_WIDTH-1:0] out_d;
    logic [PORT_WIDTH-1:0] pull_en;
    logic [PORT_WIDTH-1:0] drv_en;
    logic [PORT_WIDTH-1:0] drv_val;
    logic [PORT_WIDTH-1:0] in_en;
    logic [PORT_WIDTH-1:0] trig;

    // =========================================================
    // Port registers
    // Shared direction strobe
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dir_q <= DIR_RESET;
        end else if (dir_write_strobe_in) begin
            dir_q <= write_data_in;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pull_q <= PULL_RESET;
        end else if (pull_write_strobe_in) begin
            pull_q <= write_data_in;
        end
    end

    // Write wins; software toggle and peripheral toggle both invert
    always_comb begin
        out_d = out_q;
        if (port_write_strobe_in) begin
            out_d = write_data_in;
        end else begin
            out_d = out_q ^ toggle_override_en_in;
            if (toggle_write_strobe_in) begin
                out_d = out_d ^ write_data_in;
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            out_q <= OUT_RESET;
        end else begin
            out_q <= out_d;
        end
    end

    // =========================================================
    // Per-pin override cells
    // Peripheral-made override pairs
    for (genvar i = 0; i < PORT_WIDTH; i++) begin : g_pin
        pin_override_cell u_cell (
            .pullup_reg_bit_in        (pull_q[i]),
            .direction_reg_bit_in     (dir_q[i]),
            .output_reg_bit_in        (out_q[i]),
            .pullup_override_en_in    (pullup_override_en_in[i]),
            .pullup_override_val_in   (pullup_override_val_in[i]),
            .dir_override_en_in       (dir_override_en_in[i]),
            .dir_override_val_in      (dir_override_val_in[i]),
            .value_override_en_in     (value_override_en_in[i]),
            .value_override_val_in    (value_override_val_in[i]),
            .input_en_override_en_in  (input_en_override_en_in[i]),
            .input_en_override_val_in (input_en_override_val_in[i]),
            .sleep_in                 (sleep_in),
            .ext_int_en_in            (ext_int_en_in[i]),
            .pullup_en_out            (pull_en[i]),
            .drive_en_out             (drv_en[i]),
            .drive_val_out            (drv_val[i]),
            .input_en_out             (in_en[i])
        );
    end

    // =========================================================
    // Pad drive; disabled input clamps to ground at the trigger
    // Level held low while the driver is off, so no stale value leaks
    assign pad_oe_out     = drv_en;
    assign pad_out        = drv_val & drv_en;
    assign pad_pullup_out = pull_en;
    assign trig           = pad_in & in_en;

    assign raw_digital_in_out = trig;

    assign analog_pad_link_out = analog_pad_link_in;

    // Two flops because pads change with no regard to the clock
    // Read back lags the pad by two edges; software must allow for it
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync1_q <= SYNC_RESET;
            sync2_q <= SYNC_RESET;
        end else begin
            sync1_q <= trig;
            sync2_q <= sync1_q;
        end
    end

    // =========================================================
    // Register read back
    assign direction_reg_bit_out = dir_q;
    assign output_reg_bit_out    = out_q;
    assign pullup_reg_bit_out    = pull_q;
    assign pin_read_bit_out      = sync2_q;

    // =========================================================
    // Named alternative taps, all unsynchronised
    // Converter, reference and comparator taps share the analog link
    // Bit 0 to bit 4 functions
    assign pin_change_src_0_out = trig[PIN_A0];
    assign miso_alt_in_out      = trig[PIN_A0];
    assign converter_chan_0_out = analog_pad_link_in[PIN_A0];
    assign ext_voltage_ref_out  = analog_pad_link_in[PIN_A0];
    assign comp0_pos_in_out     = analog_pad_link_in[PIN_A1];
    assign mosi_alt_in_out      = trig[PIN_A1];
    assign comp0_neg_in_out     = analog_pad_link_in[PIN_A2];
    assign serial0_rx_out       = trig[PIN_A2];
    assign select_alt_in_out    = trig[PIN_A2];
    assign comp1_pos_in_out     = analog_pad_link_in[PIN_A3];
    assign timer0_clk_in_out    = trig[PIN_A3];
    assign serial0_xfer_clk_out = trig[PIN_A3];
    assign sck_alt_in_out       = trig[PIN_A3];
    assign comp1_neg_in_out     = analog_pad_link_in[PIN_A4];
    assign timer1_clk_in_out    = trig[PIN_A4];
    assign serial1_rx_out       = trig[PIN_A4];
    assign wire_clk_in_out      = trig[PIN_A4];
    assign sck_dflt_in_out      = trig[PIN_A4];
endmodule // port_pin_override_mux

// ==== tb/pin_mux_checker.sv ====
// Checker for the port pin override mux: pad control, register update, input paths.
// Assumes it is bound to port_pin_override_mux; pad paths are combinational.
module pin_mux_checker (
    // Clock, reset, sleep and strobes
    input wire logic       mclk_in, rst_n_in, sleep_in, port_write_strobe_in,
    input wire logic       toggle_write_strobe_in,
    // Port vectors
    input wire logic [7:0] write_data_in, output_reg_bit_out, pad_in, ext_int_en_in,
    input wire logic [7:0] direction_reg_bit_out, pullup_reg_bit_out, toggle_override_en_in,
    input wire logic [7:0] pullup_override_en_in, pullup_override_val_in,
    input wire logic [7:0] dir_override_en_in, dir_override_val_in,
    input wire logic [7:0] value_override_en_in, value_override_val_in,
    input wire logic [7:0] input_en_override_en_in, input_en_override_val_in,
    input wire logic [7:0] pad_out, pad_oe_out, pad_pullup_out,
    input wire logic [7:0] raw_digital_in_out, pin_read_bit_out,
    input wire logic [7:0] analog_pad_link_in, analog_pad_link_out,
    // Named taps
    input wire logic       pin_change_src_0_out, mosi_alt_in_out, serial0_rx_out,
    input wire logic       timer0_clk_in_out, serial1_rx_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    logic [7:0] in_en, tog;
    assign in_en = (input_en_override_en_in & input_en_override_val_in)
                 | (~input_en_override_en_in & ({8{~sleep_in}} | ext_int_en_in));
    // Both toggle sources are XORed, so both high leaves the bit alone
    assign tog = toggle_override_en_in ^ (toggle_write_strobe_in ? write_data_in : 8'h00);
    // ==========================================================
    // Pad control
    AST_PULLUP: assert property (
        pad_pullup_out == ((pullup_override_en_in & pullup_override_val_in)
        | (~pullup_override_en_in & pullup_reg_bit_out))) else $error("pull-up wrong");
    AST_DRIVE: assert property (
        pad_oe_out == ((dir_override_en_in & dir_override_val_in)
        | (~dir_override_en_in & direction_reg_bit_out))) else $error("driver enable wrong");
    AST_LEVEL: assert property (
        pad_out == (pad_oe_out & ((value_override_en_in & value_override_val_in)
        | (~value_override_en_in & output_reg_bit_out)))) else $error("driven level wrong");
    // ==========================================================
    // Register update
    AST_WRITE: assert property (
        port_write_strobe_in |=> output_reg_bit_out == $past(write_data_in))
        else $error("port write lost");
    AST_TOGGLE: assert property (
        !port_write_strobe_in |=> output_reg_bit_out == ($past(output_reg_bit_out) ^ $past(tog)))
        else $error("toggle wrong");
    // ==========================================================
    // Input paths
    AST_INPUT: assert property (
        raw_digital_in_out == (pad_in & in_en)) else $error("input enable wrong");
    AST_SYNC: assert property (
        $past(rst_n_in, 2) && $past(rst_n_in) |-> pin_read_bit_out == $past(raw_digital_in_out, 2))
        else $error("pin read delay wrong");
    AST_ANALOG: assert property (
        analog_pad_link_out == analog_pad_link_in) else $error("analog link wrong");
    AST_TAPS: assert property (
        {serial1_rx_out, timer0_clk_in_out, serial0_rx_out, mosi_alt_in_out,
        pin_change_src_0_out} == raw_digital_in_out[4:0]) else $error("tap wrong");
endmodule // pin_mux_checker

bind port_pin_override_mux pin_mux_checker u_chk (.*);

// ==== tb/pad_partner.sv ====
// Pad model: design drive, outside drive, pull-up, else a level that never settles.
// Assumes the testbench sets the outside drive; the analog source follows it.
module pad_partner (
    // Clock
    input  wire logic       mclk_in,
    // Design pad controls and outside drive
    input  wire logic [7:0] drive_val_in, drive_en_in, pull_en_in, ext_val_in, ext_en_in,
    // Pad and analog levels
    output logic      [7:0] level_out,
    output logic      [7:0] analog_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] float_q = 8'h55;
    // A floating pad must not look stable, else a lucky X resolution passes
    always @(posedge mclk_in) float_q <= ~float_q;
    assign level_out = (drive_en_in & drive_val_in) | (~drive_en_in & ext_en_in & ext_val_in)
                     | (~drive_en_in & ~ext_en_in & (pull_en_in | float_q));
    assign analog_out = ext_val_in;
endmodule // pad_partner

// ==== tb/port_pin_override_mux_tb.sv ====
// Testbench for the port pin override mux.
// Assumes a 200 MHz clock; the pad model stands on the pad side.
module port_pin_override_mux_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pin_mux_pkg::*;
    logic mclk_in = 1'b0, rst_n_in = 1'b0, sleep_in = 1'b0;
    logic dir_write_strobe_in, port_write_strobe_in, pull_write_strobe_in, toggle_write_strobe_in;
    logic [3:0] stb = 4'h0;
    logic [7:0] write_data_in = '0, pullup_override_en_in = '0, pullup_override_val_in = '0;
    logic [7:0] dir_override_en_in = '0, dir_override_val_in = '0, value_override_en_in = '0;
    logic [7:0] value_override_val_in = '0, toggle_override_en_in = '0, ext_int_en_in = '0;
    logic [7:0] input_en_override_en_in = '0, input_en_override_val_in = '0;
    logic [7:0] ext_val = '0, ext_en = '0, pad_in, analog_pad_link_in, analog_pad_link_out;
    logic [7:0] direction_reg_bit_out, output_reg_bit_out, pullup_reg_bit_out, pin_read_bit_out;
    logic [7:0] pad_out, pad_oe_out, pad_pullup_out, raw_digital_in_out;
    logic pin_change_src_0_out, miso_alt_in_out, converter_chan_0_out, ext_voltage_ref_out;
    logic comp0_pos_in_out, mosi_alt_in_out, comp0_neg_in_out, serial0_rx_out, select_alt_in_out;
    logic comp1_pos_in_out, timer0_clk_in_out, serial0_xfer_clk_out, sck_alt_in_out;
    logic comp1_neg_in_out, timer1_clk_in_out, serial1_rx_out, wire_clk_in_out, sck_dflt_in_out;
    int n_errors = 0, total_checks = 0;
    assign {dir_write_strobe_in, port_write_strobe_in, pull_write_strobe_in,
            toggle_write_strobe_in} = stb;
    port_pin_override_mux dut (.*);
    pad_partner pad (.mclk_in(mclk_in), .drive_val_in(pad_out), .drive_en_in(pad_oe_out),
        .pull_en_in(pad_pullup_out), .ext_val_in(ext_val), .ext_en_in(ext_en),
        .level_out(pad_in), .analog_out(analog_pad_link_in));
    always #2.5 mclk_in = ~mclk_in;
    // ==========================================================
    // Shared tasks
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Strobe bits: dir, port, pull, toggle; one-cycle pulse
    task automatic wr(logic [3:0] s, logic [7:0] d);
        @(posedge mclk_in);
        stb <= s;
        write_data_in <= d;
        @(posedge mclk_in);
        stb <= 4'h0;
        #1;
    endtask
    task automatic end_sim();
        if (n_errors == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    task automatic scen_plain();
        wr(4'h8, 8'hff);
        chk("dir reg", 8'hff, direction_reg_bit_out);
        wr(4'h4, 8'ha5);
        chk("oe", 8'hff, pad_oe_out);
        chk("pad", 8'ha5, pad_out);
        wr(4'h1, 8'h0f);
        chk("toggled", 8'haa, output_reg_bit_out);
        wr(4'h5, 8'h3c);
        chk("write over toggle", 8'h3c, output_reg_bit_out);
    endtask
    task automatic scen_over();
        wr(4'h2, 8'h0f);
        chk("pull reg", 8'h0f, pullup_reg_bit_out);
        @(posedge mclk_in);
        {pullup_override_en_in, dir_override_en_in, value_override_en_in} <= {3{8'hf0}};
        {pullup_override_val_in, dir_override_val_in, value_override_val_in} <= {3{8'h3c}};
        #1;
        chk("pullup", 8'h3f, pad_pullup_out);
        chk("oe ovr", 8'h3f, pad_oe_out);
        chk("pad ovr", 8'h3c, pad_out);
        @(posedge mclk_in);
        {pullup_override_en_in, dir_override_en_in, value_override_en_in} <= '0;
        toggle_override_en_in <= 8'h01;
        @(posedge mclk_in);
        toggle_override_en_in <= 8'h00;
        #1;
        chk("toggle ovr", 8'h3d, output_reg_bit_out);
    endtask
    task automatic scen_taps();
        logic [7:0] v;
        logic [7:0] dig;
        logic [7:0] ana;
        wr(4'h8, 8'h00);
        for (int k = 0; k < 2; k++) begin
            v = (k == 0) ? 8'h69 : 8'h96;
            @(posedge mclk_in);
            ext_en <= 8'hff;
            ext_val <= v;
            #1;
            dig = {1'b0, miso_alt_in_out, select_alt_in_out, sck_alt_in_out,
                   serial0_xfer_clk_out, timer1_clk_in_out, wire_clk_in_out, sck_dflt_in_out};
            ana = {2'b00, comp1_neg_in_out, comp1_pos_in_out, comp0_neg_in_out,
                   comp0_pos_in_out, converter_chan_0_out, ext_voltage_ref_out};
            chk("dig taps", {1'b0, v[0], v[2], {2{v[3]}}, {3{v[4]}}}, dig);
            chk("ana taps", {2'b00, v[4:1], {2{v[0]}}}, ana);
        end
    endtask
    task automatic scen_input();
        logic [7:0] taps;
        wr(4'h8, 8'h00);
        @(posedge mclk_in);
        ext_en <= 8'hff;
        ext_val <= 8'h96;
        repeat (3) @(posedge mclk_in);
        #1;
        taps = {3'b000, serial1_rx_out, timer0_clk_in_out, serial0_rx_out, mosi_alt_in_out,
                pin_change_src_0_out};
        chk("raw", 8'h96, raw_digital_in_out);
        chk("pin read", 8'h96, pin_read_bit_out);
        chk("taps", 8'h16, taps);
        chk("analog", 8'h96, analog_pad_link_out);
        @(posedge mclk_in);
        sleep_in <= 1'b1;
        ext_int_en_in <= 8'h06;
        #1;
        chk("sleep clamp", 8'h06, raw_digital_in_out);
        @(posedge mclk_in);
        input_en_override_en_in <= 8'h0f;
        input_en_override_val_in <= 8'h03;
        #1;
        chk("input ovr", 8'h02, raw_digital_in_out);
    endtask
    initial begin
        repeat (4) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        #1;
        chk("reset oe", DIR_RESET, pad_oe_out);
        scen_plain();
        scen_over();
        scen_taps();
        scen_input();
        end_sim();
    end
endmodule // port_pin_override_mux_tb
